// ---- logic/dtc_pkg.sv ----
// Purpose: Shared constants and types of the two-channel cycle-steal transfer controller.
// Assumes: 32-bit APB register bus, 20-bit shared memory address space.
// Notes:   Each channel owns one window of six word registers.
package dtc_pkg;

    // -------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------
    localparam int NUM_CH       = 2;           // Channel count
    localparam int ADDR_W       = 20;          // 1M-byte space
    localparam int CNT_W        = 16;          // Up to 64K units
    localparam int DATA_W       = 16;          // Widest unit
    localparam int SEL_W        = 5;           // Request source select width
    localparam int NUM_PERIPH   = 20;          // Peripheral request lines

    // -------------------------------------------------------------
    // Register map: byte offsets inside a channel window
    // -------------------------------------------------------------
    localparam logic [2:0] REG_SRC    = 3'h0;  // 0x00 source pointer
    localparam logic [2:0] REG_DST    = 3'h1;  // 0x04 destination pointer
    localparam logic [2:0] REG_RELOAD = 3'h2;  // 0x08 counter reload
    localparam logic [2:0] REG_COUNT  = 3'h3;  // 0x0C working counter, read only
    localparam logic [2:0] REG_CTRL   = 3'h4;  // 0x10 control and status
    localparam logic [2:0] REG_SEL    = 3'h5;  // 0x14 request source select
    localparam int         CH_BIT     = 5;     // Address bit picking the channel window
    localparam int         MAP_TOP    = 6;     // Address bits at and above this must be zero

    // -------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------
    localparam int CTL_EN     = 0;             // Enable
    localparam int CTL_REQ    = 1;             // Request pending, write 0 clears
    localparam int CTL_UNIT8  = 2;             // 1: byte units, 0: word units
    localparam int CTL_RPT    = 3;             // 1: repeat mode, 0: single mode
    localparam int CTL_SFWD   = 4;             // Source advances
    localparam int CTL_DFWD   = 5;             // Destination advances
    localparam int CTL_SWREQ  = 8;             // Write 1: software request

    // -------------------------------------------------------------
    // Request source select codes
    // -------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_SOFT     = 5'h00; // Software only
    localparam logic [SEL_W-1:0] SEL_EXT_FALL = 5'h01; // Pin falling edge
    localparam logic [SEL_W-1:0] SEL_EXT_BOTH = 5'h02; // Pin both edges
    localparam logic [SEL_W-1:0] SEL_PERIPH   = 5'h03; // First peripheral line

    // -------------------------------------------------------------
    // Protected region and address steps
    // -------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PROT_LO    = 20'h00020; // Own registers, first byte
    localparam logic [ADDR_W-1:0] PROT_HI    = 20'h0003F; // Own registers, last byte
    localparam logic [ADDR_W-1:0] STEP_BYTE  = 20'h00001;
    localparam logic [ADDR_W-1:0] STEP_WORD  = 20'h00002;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 16'h0000;

    // Transfer sequencer states
    typedef enum logic [1:0] {
        XF_IDLE,
        XF_READ,
        XF_WRITE
    } dtc_xfer_e;

endpackage

// ---- logic/dtc_req_src.sv ----
// Purpose: Picks and shapes the transfer request of one channel.
// Assumes: Peripheral lines are one-cycle pulses on ref_clk; the pin is asynchronous.
// Notes:   Output is a one-cycle request pulse; software requests join in the parent.
`timescale 1ns/10ps
module dtc_req_src
    import dtc_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  ext_pin,
    input  wire logic [NUM_PERIPH-1:0] periph_irq,
    input  wire logic [SEL_W-1:0]      sel,
    output logic                       req
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic s1;      // First synchroniser stage
        logic s2;      // Second synchroniser stage
        logic prev;    // Last stable level, for edge detection
    } dtc_src_s;

    dtc_src_s st;      // Registered state
    dtc_src_s next_st; // Next state
    logic     fall;    // Pin fell
    logic     rise;    // Pin rose
    logic [SEL_W-1:0] pidx; // Peripheral index

    // Synchroniser and edge history; only s2 and prev feed the edge logic
    always_comb begin
        next_st      = st;
        next_st.s1   = ext_pin;
        next_st.s2   = st.s1;
        next_st.prev = st.s2;
    end

    // Request select; unknown codes give no request
    always_comb begin
        fall = st.prev & ~st.s2;
        rise = ~st.prev & st.s2;
        pidx = sel - SEL_PERIPH;
        req  = 1'b0;
        if (sel == SEL_EXT_FALL) begin
            req = fall;
        end else if (sel == SEL_EXT_BOTH) begin
            req = fall | rise;
        end else if (sel >= SEL_PERIPH && pidx < SEL_W'(NUM_PERIPH)) begin
            req = periph_irq[pidx];
        end
    end

    // Idle pin is high, so reset to high avoids a false edge
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ---- logic/dtc_top.sv ----
// Purpose: Two-channel cycle-steal transfer controller with APB registers.
// Assumes: Shared bus slave answers with mem_ack; CPU pauses while cpu_hold is high.
// Notes:   One unit per request; read phase then write phase on the shared bus.
`timescale 1ns/10ps

module dtc_top
    import dtc_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Request sources
    input  wire logic                  ext_edge_in_a,
    input  wire logic                  ext_edge_in_b,
    input  wire logic [NUM_PERIPH-1:0] periph_irq,
    // Shared bus master
    output logic                       cpu_hold,
    output logic                       mem_req,
    output logic                       mem_we,
    output logic                       mem_size16,
    output logic [ADDR_W-1:0]          mem_addr,
    output logic [DATA_W-1:0]          mem_wdata,
    input  wire logic [DATA_W-1:0]     mem_rdata,
    input  wire logic                  mem_ack,
    // Underflow events
    output logic [NUM_CH-1:0]          dma_irq
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        dtc_xfer_e                     fsm;    // Sequencer state
        logic                          ch;     // Channel being served
        logic [NUM_CH-1:0]             en;     // Enable bits
        logic [NUM_CH-1:0]             req;    // Sticky request bits
        logic [NUM_CH-1:0]             fresh;  // Next transfer reloads
        logic [NUM_CH-1:0]             unit8;  // Byte units
        logic [NUM_CH-1:0]             rpt;    // Repeat mode
        logic [NUM_CH-1:0]             sfwd;   // Source forward
        logic [NUM_CH-1:0]             dfwd;   // Destination forward
        logic [NUM_CH-1:0][ADDR_W-1:0] sptr;   // Source pointer register
        logic [NUM_CH-1:0][ADDR_W-1:0] dptr;   // Destination pointer register
        logic [NUM_CH-1:0][ADDR_W-1:0] wptr;   // Working forward pointer
        logic [NUM_CH-1:0][CNT_W-1:0]  rld;    // Counter reload
        logic [NUM_CH-1:0][CNT_W-1:0]  cnt;    // Working counter
        logic [NUM_CH-1:0][SEL_W-1:0]  sel;    // Request source select
        logic [ADDR_W-1:0]             xdst;   // Destination of current unit
        logic [ADDR_W-1:0]             maddr;  // Bus address
        logic [DATA_W-1:0]             mwdata; // Bus write data
        logic                          mwe;    // Bus direction
        logic [31:0]                   rdata;  // APB read data
        logic                          err;    // APB error
        logic [NUM_CH-1:0]             irq;    // Underflow pulse
    } dtc_state_s;

    dtc_state_s        st;      // Registered state
    dtc_state_s        next_st; // Next state
    logic [NUM_CH-1:0] src_req; // Hardware request pulses
    logic [NUM_CH-1:0] elig;    // Enabled and pending
    logic [NUM_CH-1:0] uflow;   // Underflow this cycle
    logic [NUM_CH-1:0] ext_pin; // Per-channel pin

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    // Register window address check, used for read and write
    function automatic logic dec_ok(input logic [31:0] a);
        return (a[31:MAP_TOP] == '0) && (a[4:2] <= REG_SEL);
    endfunction

    // Shared-bus address falls inside our own registers
    function automatic logic blocked(input logic [ADDR_W-1:0] a);
        return (a >= PROT_LO) && (a <= PROT_HI);
    endfunction

    // -------------------------------------------------------------
    // Request sources, one per channel
    // -------------------------------------------------------------
    assign ext_pin = {ext_edge_in_b, ext_edge_in_a}; // Channel one owns the second pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_src
            dtc_req_src u_src (
                .ref_clk    (ref_clk),
                .rst_b      (rst_b),
                .ext_pin    (ext_pin[gi]),
                .periph_irq (periph_irq),
                .sel        (st.sel[gi]),
                .req        (src_req[gi])
            );
        end
    endgenerate

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    // Suppressed strobes keep our own region out of reach
    always_comb begin
        elig       = st.en & st.req;
        mem_req    = (st.fsm != XF_IDLE) && !blocked(st.maddr);
        mem_we     = st.mwe;
        mem_size16 = !st.unit8[st.ch];
        mem_addr   = st.maddr;
        mem_wdata  = st.mwdata;
        cpu_hold   = (st.fsm != XF_IDLE);
        prdata     = st.rdata;
        pready     = 1'b1;
        pslverr    = st.err;
        dma_irq    = st.irq;
        for (int i = 0; i < NUM_CH; i++) begin
            uflow[i] = (st.fsm == XF_WRITE) && (st.ch == 1'(i)) &&
                       (mem_ack || blocked(st.maddr)) && (st.cnt[i] == CNT_ZERO);
        end
    end

    // -------------------------------------------------------------
    // Next state: sequencer, then software, then hardware request set
    // -------------------------------------------------------------
    always_comb begin
        logic              c;
        logic [2:0]        r;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] xsrc;
        logic [NUM_CH-1:0] sw_trig;
        c       = 1'b0;
        r       = paddr[4:2];
        base    = '0;
        xsrc    = '0;
        sw_trig = '0;
        next_st     = st;
        next_st.irq = '0;

        // Transfer sequencer
        case (st.fsm)
            XF_IDLE: begin
                if (elig != '0) begin
                    c = elig[0] ? 1'b0 : 1'b1;
                    next_st.ch     = c;
                    next_st.req[c] = 1'b0;
                    if (st.fresh[c]) begin
                        base              = st.sfwd[c] ? st.sptr[c] : st.dptr[c];
                        next_st.cnt[c]    = st.rld[c];
                        next_st.fresh[c]  = 1'b0;
                    end else begin
                        base = st.wptr[c];
                    end
                    next_st.wptr[c] = base;
                    xsrc            = st.sfwd[c] ? base : st.sptr[c];
                    next_st.xdst    = st.dfwd[c] ? base : st.dptr[c];
                    next_st.maddr   = xsrc;
                    next_st.mwe     = 1'b0;
                    next_st.fsm     = XF_READ;
                end
            end
            XF_READ: begin
                // A blocked read moves zero instead of touching the region
                if (mem_ack || blocked(st.maddr)) begin
                    next_st.mwdata = blocked(st.maddr) ? '0 : mem_rdata;
                    next_st.maddr  = st.xdst;
                    next_st.mwe    = 1'b1;
                    next_st.fsm    = XF_WRITE;
                end
            end
            XF_WRITE: begin
                if (mem_ack || blocked(st.maddr)) begin
                    c = st.ch;
                    next_st.wptr[c] = st.wptr[c] + (st.unit8[c] ? STEP_BYTE : STEP_WORD);
                    if (uflow[c]) begin
                        next_st.irq[c] = 1'b1;
                        if (st.rpt[c]) begin
                            next_st.cnt[c] = st.rld[c];
                        end else begin
                            next_st.en[c] = 1'b0;
                        end
                    end else begin
                        next_st.cnt[c] = st.cnt[c] - CNT_ONE;
                    end
                    next_st.mwe = 1'b0;
                    next_st.fsm = XF_IDLE;
                end
            end
            default: begin
                next_st.fsm = XF_IDLE;
            end
        endcase

        // APB setup phase: capture read data and error
        if (psel && !penable) begin
            c             = paddr[CH_BIT];
            next_st.err   = !dec_ok(paddr);
            next_st.rdata = '0;
            if (!dec_ok(paddr)) begin
                next_st.rdata = '0;
            end else if (r == REG_SRC) begin
                next_st.rdata[ADDR_W-1:0] = (st.en[c] && st.sfwd[c]) ? st.wptr[c]
                                                                      : st.sptr[c];
            end else if (r == REG_DST) begin
                next_st.rdata[ADDR_W-1:0] = (st.en[c] && st.dfwd[c]) ? st.wptr[c]
                                                                      : st.dptr[c];
            end else if (r == REG_RELOAD) begin
                next_st.rdata[CNT_W-1:0] = st.rld[c];
            end else if (r == REG_COUNT) begin
                next_st.rdata[CNT_W-1:0] = st.cnt[c];
            end else if (r == REG_CTRL) begin
                next_st.rdata[CTL_EN]    = st.en[c];
                next_st.rdata[CTL_REQ]   = st.req[c];
                next_st.rdata[CTL_UNIT8] = st.unit8[c];
                next_st.rdata[CTL_RPT]   = st.rpt[c];
                next_st.rdata[CTL_SFWD]  = st.sfwd[c];
                next_st.rdata[CTL_DFWD]  = st.dfwd[c];
            end else begin
                next_st.rdata[SEL_W-1:0] = st.sel[c];
            end
        end

        // APB access phase: writes take effect here, after the sequencer
        if (psel && penable && pwrite && dec_ok(paddr)) begin
            c = paddr[CH_BIT];
            if (r == REG_SRC) begin
                if (st.sfwd[c] || !st.en[c]) begin
                    next_st.sptr[c] = pwdata[ADDR_W-1:0];
                end
            end else if (r == REG_DST) begin
                if (st.dfwd[c] || !st.en[c]) begin
                    next_st.dptr[c] = pwdata[ADDR_W-1:0];
                end
            end else if (r == REG_RELOAD) begin
                next_st.rld[c] = pwdata[CNT_W-1:0];
            end else if (r == REG_CTRL) begin
                next_st.en[c]    = pwdata[CTL_EN];
                next_st.fresh[c] = pwdata[CTL_EN] | st.fresh[c];
                if (!pwdata[CTL_REQ]) begin
                    next_st.req[c] = 1'b0;
                end
                next_st.unit8[c] = pwdata[CTL_UNIT8];
                next_st.rpt[c]   = pwdata[CTL_RPT];
                next_st.sfwd[c]  = pwdata[CTL_SFWD];
                next_st.dfwd[c]  = pwdata[CTL_DFWD] & ~pwdata[CTL_SFWD];
                sw_trig[c]       = pwdata[CTL_SWREQ];
            end else if (r == REG_SEL) begin
                next_st.sel[c] = pwdata[SEL_W-1:0];
            end
        end

        // Requests set last so a new one beats any clear; repeats merge
        for (int i = 0; i < NUM_CH; i++) begin
            if (src_req[i] || sw_trig[i]) begin
                next_st.req[i] = 1'b1;
            end
        end
    end

    // Register the whole state
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    chk_cpu_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mem_req |-> cpu_hold)
        else $error("bus used without holding the CPU");

    chk_ch0_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st.fsm == XF_IDLE && elig == 2'b11) |=> (st.ch == 1'b0 && st.fsm == XF_READ))
        else $error("channel one served before channel zero");

    chk_region_block: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mem_req |-> !(mem_addr >= PROT_LO && mem_addr <= PROT_HI))
        else $error("transfer touched own register region");

    chk_single_stop: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (uflow[0] && !st.rpt[0] && !(psel && penable && pwrite)) |=> !st.en[0])
        else $error("single mode left channel enabled");

    chk_repeat_reload: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (uflow[1] && st.rpt[1] && !(psel && penable && pwrite))
        |=> (st.cnt[1] == $past(st.rld[1]) && st.en[1] == $past(st.en[1])))
        else $error("repeat mode did not reload the counter");

    chk_irq_uflow: assert property (@(posedge ref_clk) disable iff (!rst_b)
        uflow[0] |=> dma_irq[0] ##1 !dma_irq[0])
        else $error("underflow interrupt pulse missing or long");

    chk_idle_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st.fsm == XF_IDLE && st.en == '0) |=> st.fsm == XF_IDLE)
        else $error("disabled channel started a transfer");

    chk_no_dual_fwd: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st.sfwd & st.dfwd) == '0)
        else $error("both sides forward");

    chk_unit_size: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st.fsm == XF_READ) |-> (mem_size16 == !st.unit8[st.ch] && !mem_we))
        else $error("wrong unit size or direction in read phase");

    chk_count_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st.fsm == XF_WRITE && mem_ack && st.cnt[st.ch] != CNT_ZERO && !psel)
        |=> st.cnt[$past(st.ch)] == $past(st.cnt[st.ch]) - CNT_ONE)
        else $error("counter did not step down by one");

    chk_req_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st.fsm == XF_IDLE && elig[0] && !src_req[0] && !psel) |=> !st.req[0])
        else $error("request bit not cleared at transfer start");

endmodule

// ---- sim/dtc_mem_model.sv ----
// Purpose: Shared-bus memory standing beside the transfer controller.
// Assumes: One 16-bit word per even byte address, 256 words.
// Notes:   Away from an ack the read data is inverted so stale data never matches.
`timescale 1ns/10ps
module dtc_mem_model
    import dtc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              mem_req,
    input  wire logic              mem_we,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] mem_wdata,
    input  wire logic [1:0]        slow,
    output logic [DATA_W-1:0]      mem_rdata = 16'h0000,
    output logic                   mem_ack = 1'b0
);
    // ---------------------------------------------------------
    // Storage and wait state
    // ---------------------------------------------------------
    logic [DATA_W-1:0] store [0:255];  // Word store
    logic [1:0]        wait_n = 2'h0;  // Idle cycles in this phase
    // Answer a phase after slow cycles; a write lands at its ack edge
    always @(posedge ref_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        wait_n <= 2'h0;
        if (mem_ack && mem_we) begin
            store[mem_addr[8:1]] <= mem_wdata;
        end
        if (mem_req && !mem_ack) begin
            if (wait_n >= slow) begin
                mem_ack <= 1'b1;
                mem_rdata <= store[mem_addr[8:1]];
            end else begin
                wait_n <= wait_n + 2'h1;
            end
        end
    end
endmodule

// ---- sim/dtc_top_test.sv ----
// Purpose: Self-checking bench of the transfer controller over APB.
// Assumes: Zero-wait APB; memory model answers promptly or slowly.
// Notes:   Pins idle high; requests come from peripheral lines and pin edges.
`timescale 1ns/10ps
module dtc_top_test;
    import dtc_pkg::*;
    logic                  ref_clk, pready, pslverr, cpu_hold, mem_req, mem_we, mem_ack, err;
    logic                  rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, grab = 1'b0;
    logic                  pin_a = 1'b1, pin_b = 1'b1;
    logic [31:0]           paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [NUM_PERIPH-1:0] periph_irq = '0;
    logic [ADDR_W-1:0]     mem_addr, first_a = '0;
    logic [DATA_W-1:0]     mem_wdata, mem_rdata;
    logic [NUM_CH-1:0]     dma_irq;
    logic [1:0]            slow = 2'h0;
    int                    fail_count = 0, checks_done = 0, cycles = 0, irq0 = 0, irq1 = 0;
    dtc_top DUT (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_edge_in_a(pin_a), .ext_edge_in_b(pin_b), .periph_irq,
        .cpu_hold, .mem_req, .mem_we, .mem_size16(), .mem_addr, .mem_wdata, .mem_rdata,
        .mem_ack, .dma_irq);
    dtc_mem_model mem (.ref_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .slow,
        .mem_rdata, .mem_ack);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Count underflow pulses, catch the first bus address, cut hangs short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (dma_irq[0] === 1'b1) irq0 <= irq0 + 1;
        if (dma_irq[1] === 1'b1) irq1 <= irq1 + 1;
        if (grab && mem_req === 1'b1) begin
            first_a <= mem_addr;
            grab <= 1'b0;
        end
        if (cycles == 3000) begin
            fail_count++;
            final_report;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse(input logic [NUM_PERIPH-1:0] m);
        @(posedge ref_clk) periph_irq <= m;
        @(posedge ref_clk) periph_irq <= '0;
    endtask
    // Wait, bounded, for one unit to start and finish
    task xfer;
        int n;
        n = 0;
        while (cpu_hold !== 1'b1 && n < 60) begin @(negedge ref_clk); n++; end
        while (cpu_hold !== 1'b0 && n < 60) begin @(negedge ref_clk); n++; end
    endtask
    task final_report;
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        mem.store[8'h20] = 16'h1234;
        mem.store[8'h21] = 16'hABCD;
        mem.store[8'h80] = 16'h5A5A;
        apb(0, 32'h10, 0); chk(rd, 32'h0);
        apb(0, 32'h40, 0); chk(err, 1'b1);
        // Channel zero, single mode, word units, forward source, slow memory
        slow <= 2'h2;
        apb(1, 32'h00, 32'h40); apb(1, 32'h04, 32'hC0); apb(1, 32'h08, 1);
        apb(1, 32'h14, 3); apb(1, 32'h10, 32'h11);
        pulse(1); xfer;
        apb(0, 32'h00, 0); chk(rd, 32'h42);
        apb(0, 32'h0C, 0); chk(rd, 32'h0);
        apb(1, 32'h04, 32'h180); apb(0, 32'h04, 0); chk(rd, 32'hC0);
        chk(mem.store[8'h60], 16'h1234);
        pulse(1); xfer;
        chk(mem.store[8'h60], 16'hABCD);
        apb(0, 32'h10, 0); chk(rd[1:0], 2'h0);
        chk(irq0, 1);
        pulse(1); apb(0, 32'h10, 0); chk(rd[1:0], 2'h2);
        apb(1, 32'h10, 0); apb(0, 32'h10, 0); chk(rd[1], 1'b0);
        // Channel one repeat fixed-to-fixed against a restarted channel zero
        slow <= 2'h0;
        apb(1, 32'h20, 32'h100); apb(1, 32'h24, 32'h180); apb(1, 32'h28, 0);
        apb(1, 32'h34, 4); apb(1, 32'h30, 32'h09); apb(1, 32'h10, 32'h11);
        grab <= 1'b1;
        pulse(3); xfer; xfer;
        chk(first_a, 20'h00040);
        chk(mem.store[8'hC0], 16'h5A5A);
        apb(0, 32'h30, 0); chk(rd[0], 1'b1);
        chk(irq1, 1);
        apb(0, 32'h00, 0); chk(rd, 32'h42);
        // Channel zero on its pin's falling edge, restarted onto a blocked source
        apb(1, 32'h00, 32'h20); apb(1, 32'h14, 1); apb(1, 32'h10, 32'h11);
        pin_a <= 1'b0;
        xfer;
        chk(mem.store[8'h60], 16'h0);
        apb(0, 32'h00, 0); chk(rd, 32'h22);
        // Channel one on both edges of its own pin; rising pin_a must not start zero
        apb(1, 32'h34, 2);
        pin_b <= 1'b0;
        xfer;
        @(posedge ref_clk);
        pin_a <= 1'b1;
        pin_b <= 1'b1;
        xfer;
        apb(0, 32'h10, 0); chk(rd[1:0], 2'h1);
        chk(irq0, 1);
        apb(0, 32'h30, 0); chk(irq1, 3);
        final_report;
    end
endmodule
